// *** rtl/fsei_pkg.sv ***
// constants shared by the fieldbus slave event indication block
package fsei_pkg;

  // ********************************************************************
  // event bit layout of the request word
  // ********************************************************************
  localparam int unsigned EVT_W = 16;
  localparam int unsigned EV_DATAEX = 0;
  localparam int unsigned EV_OFFLINE = 1;
  localparam int unsigned EV_BAUD = 2;
  localparam int unsigned EV_WDOG = 3;
  localparam int unsigned EV_TIMER = 4;
  localparam int unsigned EV_GC = 5;
  localparam int unsigned EV_ADDR = 6;
  localparam int unsigned EV_CFG = 7;
  localparam int unsigned EV_PRM = 8;
  localparam int unsigned EV_DIAG = 9;
  localparam int unsigned EV_OUT = 10;
  localparam logic [15:0] EVT_USED = 16'h07ff;

  // ********************************************************************
  // register map, byte addresses
  // ********************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_IND = 8'h00;
  localparam logic [7:0] A_POLL = 8'h04;
  localparam logic [7:0] A_ACK = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_GCCELL = 8'h14;
  localparam logic [7:0] A_TEST = 8'h40;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [7:0] GC_CELL_RST = 8'h00;

  // control register fields
  localparam int unsigned CB_GO_OFFLINE = 0;
  localparam int unsigned CB_DIAG_SWAP = 1;
  localparam int unsigned CB_EOI = 2;
  localparam int unsigned CB_GO_ONLINE = 3;
  // control read-back fields
  localparam int unsigned CS_GO_OFFLINE = 0;
  localparam int unsigned CS_OFFLINE = 1;
  localparam int unsigned CS_IN_SERVICE = 2;
  localparam int unsigned CS_DIAG_SEL = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TIMER_PERIOD_NS = 10000000;
  localparam int unsigned TICK_CYCLES_DFLT = TIMER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 20;

endpackage : fsei_pkg

// *** rtl/fsei_edge.sv ***
// rise and fall detector for a same-clock level
`timescale 1ns/1ps
`default_nettype none
module fsei_edge (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_r;
  assign fall_o = ~level_i & prev_r;

endmodule : fsei_edge
`default_nettype wire

// *** rtl/fsei_tick.sv ***
// free running time base giving a one-cycle tick per period
`timescale 1ns/1ps
`default_nettype none
module fsei_tick #(
  parameter int unsigned TICK_CYCLES = fsei_pkg::TICK_CYCLES_DFLT
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  localparam logic [fsei_pkg::TICK_CNT_W-1:0] LAST =
    fsei_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  logic [fsei_pkg::TICK_CNT_W-1:0] cnt_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule : fsei_tick
`default_nettype wire

// *** rtl/fsei_top.sv ***
// event indication unit of a fieldbus slave controller with an axi4-lite register port
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fsei_top #(
  parameter int unsigned TICK_CYCLES = fsei_pkg::TICK_CYCLES_DFLT
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // axi4-lite slave
  input wire logic [fsei_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fsei_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // protocol engine side
  input wire logic cyclic_exchange_state_i,
  input wire logic req_busy_i,
  input wire logic baud_search_i,
  input wire logic baud_rate_valid_i,
  input wire logic wd_expire_i,
  input wire logic master_supervised_state_i,
  input wire logic gc_rx_i,
  input wire logic [7:0] broadcast_control_byte_i,
  input wire logic address_change_stored_i,
  input wire logic cfg_stored_i,
  input wire logic prm_stored_i,
  input wire logic out_stored_i,
  input wire logic master_leave_i,
  output logic irq_o,
  output logic offline_o,
  output logic go_offline_o,
  output logic diag_swap_o,
  output logic diag_buf_sel_o,
  output logic out_clear_o,
  output logic [7:0] broadcast_control_cell_o
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [fsei_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_nxt;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [15:0] lane_mask, pend_r, pend_nxt, mask_r, evt, ack_vec;
  logic wr_fire, ar_hs, mask_we, ctrl_we, ind_read;
  logic go_offline_r, offline_r, in_service_r, diag_sel_r, por_pending_r;
  logic [7:0] gc_cell_r;
  logic offline_done, diag_req, eoi_req, online_req, clear_req, gc_new;
  logic dx_rise, dx_fall, baud_fall, tick;
  // ********************************************************************
  // event sources
  // ********************************************************************
  fsei_edge u_dx_edge (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .level_i(cyclic_exchange_state_i),
    .rise_o(dx_rise), .fall_o(dx_fall));
  fsei_edge u_baud_edge (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .level_i(baud_search_i),
    .rise_o(), .fall_o(baud_fall));
  fsei_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .tick_o(tick));
  assign offline_done = go_offline_r & ~req_busy_i;
  assign gc_new = gc_rx_i & (broadcast_control_byte_i != gc_cell_r);
  assign clear_req = por_pending_r | master_leave_i;
  always_comb begin
    evt = '0;
    evt[fsei_pkg::EV_DATAEX] = dx_rise | dx_fall;
    evt[fsei_pkg::EV_OFFLINE] = offline_done;
    evt[fsei_pkg::EV_BAUD] = baud_fall & baud_rate_valid_i;
    evt[fsei_pkg::EV_WDOG] = wd_expire_i & master_supervised_state_i;
    evt[fsei_pkg::EV_TIMER] = tick;
    evt[fsei_pkg::EV_GC] = gc_new;
    evt[fsei_pkg::EV_ADDR] = address_change_stored_i;
    evt[fsei_pkg::EV_CFG] = cfg_stored_i;
    evt[fsei_pkg::EV_PRM] = prm_stored_i;
    evt[fsei_pkg::EV_DIAG] = diag_req;
    evt[fsei_pkg::EV_OUT] = out_stored_i | clear_req;
  end

  // ********************************************************************
  // request word
  // ********************************************************************
  // set wins over acknowledge
  assign pend_nxt = ((pend_r & ~ack_vec) | evt) & fsei_pkg::EVT_USED;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= fsei_pkg::MASK_RST;
    end else if (mask_we) begin
      mask_r <= ((mask_r & ~lane_mask) | (w_data_r[15:0] & lane_mask)) & fsei_pkg::EVT_USED;
    end
  end

  // ********************************************************************
  // offline, diagnostics swap, output clear, broadcast cell
  // ********************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_offline_r <= 1'b0;
      offline_r <= 1'b0;
    end else begin
      if (offline_done) begin
        go_offline_r <= 1'b0;
        offline_r <= 1'b1;
      end else if (ctrl_we && w_data_r[fsei_pkg::CB_GO_OFFLINE]) begin
        go_offline_r <= 1'b1;
      end
      if (online_req && !offline_done) begin
        offline_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_sel_r <= 1'b0;
      diag_swap_o <= 1'b0;
    end else begin
      diag_swap_o <= diag_req;
      if (diag_req) begin
        diag_sel_r <= ~diag_sel_r;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_pending_r <= 1'b1;
      out_clear_o <= 1'b0;
    end else begin
      por_pending_r <= 1'b0;
      out_clear_o <= clear_req;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gc_cell_r <= fsei_pkg::GC_CELL_RST;
    end else if (gc_new) begin
      gc_cell_r <= broadcast_control_byte_i;
    end
  end

  // ********************************************************************
  // indication sequence and interrupt
  // ********************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_service_r <= 1'b0;
    end else if (ind_read) begin
      in_service_r <= 1'b1;
    end else if (eoi_req) begin
      in_service_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (|(pend_r & mask_r)) & ~in_service_r;
    end
  end

  // ********************************************************************
  // axi4-lite write channel
  // ********************************************************************
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    bvalid_nxt = bvalid_r;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full_nxt = 1'b1;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end else if (bvalid_r && s_axi_bready_i) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    ack_vec = '0;
    mask_we = 1'b0;
    ctrl_we = 1'b0;
    bresp_nxt = fsei_pkg::RESP_OKAY;
    if (wr_fire) begin
      if (aw_addr_r[7:6] == fsei_pkg::A_TEST[7:6]) begin
        // single event acknowledge by writing one to its test word
        ack_vec[aw_addr_r[5:2]] = w_data_r[0] & w_strb_r[0];
      end else if (aw_addr_r[7:2] == fsei_pkg::A_ACK[7:2]) begin
        ack_vec = w_data_r[15:0] & lane_mask;
      end else if (aw_addr_r[7:2] == fsei_pkg::A_MASK[7:2]) begin
        mask_we = 1'b1;
      end else if (aw_addr_r[7:2] == fsei_pkg::A_CTRL[7:2]) begin
        ctrl_we = w_strb_r[0];
      end else begin
        bresp_nxt = fsei_pkg::RESP_SLVERR;
      end
    end
  end

  assign diag_req = ctrl_we & w_data_r[fsei_pkg::CB_DIAG_SWAP];
  assign eoi_req = ctrl_we & w_data_r[fsei_pkg::CB_EOI];
  assign online_req = ctrl_we & w_data_r[fsei_pkg::CB_GO_ONLINE];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bresp_o <= fsei_pkg::RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      bvalid_r <= bvalid_nxt;
      s_axi_awready_o <= ~aw_full_nxt & ~bvalid_nxt;
      s_axi_wready_o <= ~w_full_nxt & ~bvalid_nxt;
      if (wr_fire) begin
        s_axi_bresp_o <= bresp_nxt;
      end
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_r;

  // ********************************************************************
  // axi4-lite read channel
  // ********************************************************************
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  assign ind_read = ar_hs & (s_axi_araddr_i[7:2] == fsei_pkg::A_IND[7:2]);
  assign rvalid_nxt = ar_hs ? 1'b1 : ((rvalid_r && s_axi_rready_i) ? 1'b0 : rvalid_r);

  always_comb begin
    rdata_nxt = '0;
    rresp_nxt = fsei_pkg::RESP_OKAY;
    if (s_axi_araddr_i[7:6] == fsei_pkg::A_TEST[7:6]) begin
      rdata_nxt[0] = pend_r[s_axi_araddr_i[5:2]];
    end else if (s_axi_araddr_i[7:2] == fsei_pkg::A_IND[7:2] ||
                 s_axi_araddr_i[7:2] == fsei_pkg::A_POLL[7:2]) begin
      rdata_nxt[15:0] = pend_r;
    end else if (s_axi_araddr_i[7:2] == fsei_pkg::A_MASK[7:2]) begin
      rdata_nxt[15:0] = mask_r;
    end else if (s_axi_araddr_i[7:2] == fsei_pkg::A_CTRL[7:2]) begin
      rdata_nxt[fsei_pkg::CS_GO_OFFLINE] = go_offline_r;
      rdata_nxt[fsei_pkg::CS_OFFLINE] = offline_r;
      rdata_nxt[fsei_pkg::CS_IN_SERVICE] = in_service_r;
      rdata_nxt[fsei_pkg::CS_DIAG_SEL] = diag_sel_r;
    end else if (s_axi_araddr_i[7:2] == fsei_pkg::A_GCCELL[7:2]) begin
      rdata_nxt[7:0] = gc_cell_r;
    end else if (s_axi_araddr_i[7:2] != fsei_pkg::A_ACK[7:2]) begin
      rresp_nxt = fsei_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      s_axi_arready_o <= 1'b1;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= fsei_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      s_axi_arready_o <= ~rvalid_nxt;
      if (ar_hs) begin
        s_axi_rdata_o <= rdata_nxt;
        s_axi_rresp_o <= rresp_nxt;
      end
    end
  end
  assign s_axi_rvalid_o = rvalid_r;
  assign offline_o = offline_r;
  assign go_offline_o = go_offline_r;
  assign diag_buf_sel_o = diag_sel_r;
  assign broadcast_control_cell_o = gc_cell_r;

endmodule : fsei_top
`default_nettype wire

// *** tb/fsei_chk.sv ***
// assertion checker for the event indication unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module fsei_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic req_busy_i,
  input wire logic gc_rx_i,
  input wire logic [7:0] broadcast_control_byte_i,
  input wire logic master_leave_i,
  input wire logic offline_o,
  input wire logic go_offline_o,
  input wire logic diag_swap_o,
  input wire logic diag_buf_sel_o,
  input wire logic out_clear_o,
  input wire logic [7:0] broadcast_control_cell_o
);
  // ********************************************************************
  // properties
  // ********************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid_o;
  endproperty
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  property p_rd_done;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
  endproperty
  property p_cell_upd;
    gc_rx_i && (broadcast_control_byte_i != broadcast_control_cell_o)
      |=> broadcast_control_cell_o == $past(broadcast_control_byte_i);
  endproperty
  property p_cell_hold;
    !gc_rx_i |=> $stable(broadcast_control_cell_o);
  endproperty
  property p_leave_clr;
    master_leave_i |=> out_clear_o;
  endproperty
  property p_swap_tog;
    diag_swap_o |-> diag_buf_sel_o != $past(diag_buf_sel_o);
  endproperty
  property p_sel_cause;
    $changed(diag_buf_sel_o) |-> diag_swap_o;
  endproperty
  property p_off_idle;
    $rose(offline_o) |-> !$past(req_busy_i);
  endproperty
  property p_off_wait;
    go_offline_o && req_busy_i |=> go_offline_o && !$rose(offline_o);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_rd_done: assert property (p_rd_done) else $error("read not closed");
  a_cell_upd: assert property (p_cell_upd) else $error("cell not loaded");
  a_cell_hold: assert property (p_cell_hold) else $error("cell changed alone");
  a_leave_clr: assert property (p_leave_clr) else $error("no output clear");
  a_swap_tog: assert property (p_swap_tog) else $error("swap without toggle");
  a_sel_cause: assert property (p_sel_cause) else $error("toggle without swap");
  a_off_idle: assert property (p_off_idle) else $error("offline while busy");
  a_off_wait: assert property (p_off_wait) else $error("go offline dropped");
endmodule : fsei_chk
bind fsei_top fsei_chk u_fsei_chk (.*);
`default_nettype wire

// *** tb/fsei_host.sv ***
// host model: axi4-lite master that reads and acknowledges event requests
`timescale 1ns/1ps
`default_nettype none
module fsei_host (
  input wire logic mclk_i,
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic bvalid_i,
  input wire logic [1:0] bresp_i,
  input wire logic arready_i,
  input wire logic rvalid_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, araddr_o, arvalid_o} = '0;
    bready_o = 1'b1;
    rready_o = 1'b1;
  end
  // ack words use the request word layout
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    while (pa || pw) begin
      @(posedge mclk_i);
      if (pa && awready_i) begin
        pa = 1'b0;
        awvalid_o <= 1'b0;
      end
      if (pw && wready_i) begin
        pw = 1'b0;
        wvalid_o <= 1'b0;
      end
    end
    do @(posedge mclk_i); while (!bvalid_i);
    r = bresp_i;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    do @(posedge mclk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge mclk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
  endtask : rd
endmodule : fsei_host
`default_nettype wire

// *** tb/fsei_tb_top.sv ***
// self-checking bench for the event indication unit
`timescale 1ns/1ps
`default_nettype none
module fsei_tb_top;
  localparam int unsigned TICKS = 20;
  localparam logic [31:0] NT = 32'h0000ffef;
  logic mclk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic s_axi_rready_i, cyclic_exchange_state_i, req_busy_i, baud_search_i, baud_rate_valid_i;
  logic wd_expire_i, master_supervised_state_i, gc_rx_i, address_change_stored_i;
  logic cfg_stored_i, prm_stored_i, out_stored_i, master_leave_i, irq_o, offline_o;
  logic go_offline_o, diag_swap_o, diag_buf_sel_o, out_clear_o, s;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, broadcast_control_byte_i;
  logic [7:0] broadcast_control_cell_o, exp_cell;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [15:0] exp_ev;
  int num_errors = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int tab[9] = '{0, 2, 3, 5, 6, 7, 8, 10, 11};
  fsei_top #(.TICK_CYCLES(TICKS)) u_fsei_top (.*);
  fsei_host u_fsei_host (.mclk_i(mclk_i), .awready_i(s_axi_awready_o),
    .wready_i(s_axi_wready_o), .bvalid_i(s_axi_bvalid_o), .bresp_i(s_axi_bresp_o),
    .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i),
    .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i),
    .rready_o(s_axi_rready_i));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // master leave shares the output-data bit
  function automatic int evbit(input int i);
    return (i == 11) ? 10 : i;
  endfunction : evbit
  task automatic poll();
    u_fsei_host.rd(fsei_pkg::A_POLL, rd_d, rsp);
    chk(rd_d & NT, {16'h0000, exp_ev} & NT);
  endtask : poll
  task automatic fire(input int i, input logic v);
    logic [7:0] b;
    b = v ? 8'($urandom) : exp_cell;
    case (i)
      0: cyclic_exchange_state_i <= ~cyclic_exchange_state_i;
      2: {baud_search_i, baud_rate_valid_i} <= {1'b0, v};
      3: {wd_expire_i, master_supervised_state_i} <= {1'b1, v};
      5: {gc_rx_i, broadcast_control_byte_i} <= {1'b1, b};
      6: address_change_stored_i <= 1'b1;
      7: cfg_stored_i <= 1'b1;
      8: prm_stored_i <= 1'b1;
      10: out_stored_i <= 1'b1;
      default: master_leave_i <= 1'b1;
    endcase
    if (!((i == 2 || i == 3) && !v) && !(i == 5 && b == exp_cell)) exp_ev[evbit(i)] = 1'b1;
    if (i == 5) exp_cell = b;
    @(posedge mclk_i);
    {wd_expire_i, gc_rx_i, address_change_stored_i, cfg_stored_i} <= '0;
    {prm_stored_i, out_stored_i, master_leave_i, baud_search_i} <= 4'b0001;
    repeat (2) @(posedge mclk_i);
  endtask : fire
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    {cyclic_exchange_state_i, req_busy_i, wd_expire_i, master_supervised_state_i} = '0;
    {gc_rx_i, broadcast_control_byte_i, address_change_stored_i, cfg_stored_i} = '0;
    {prm_stored_i, out_stored_i, master_leave_i, rst_n_i} = '0;
    {baud_search_i, baud_rate_valid_i} = 2'b11;
    exp_ev = 16'h0400;
    exp_cell = 8'h00;
    void'($urandom(32'h1621));
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    poll();
    u_fsei_host.rd(fsei_pkg::A_MASK, rd_d, rsp);
    chk(rd_d, 32'h00000000);
    u_fsei_host.rd(8'h20, rd_d, rsp);
    chk({30'h0, rsp}, {30'h0, fsei_pkg::RESP_SLVERR});
    for (int n = 0; n < 60; n++) begin
      int i;
      int k;
      int e;
      logic [15:0] w;
      i = tab[$urandom_range(0, 8)];
      k = $urandom_range(0, 2);
      w = 16'($urandom);
      e = evbit(i);
      fire(i, 1'($urandom_range(0, 1)));
      poll();
      u_fsei_host.rd(fsei_pkg::A_TEST + 8'(4 * e), rd_d, rsp);
      chk(rd_d, {31'h0, exp_ev[e]});
      if (k == 0) u_fsei_host.wr(fsei_pkg::A_TEST + 8'(4 * e), 32'h1, 4'h1, rsp);
      else u_fsei_host.wr(fsei_pkg::A_ACK, k == 1 ? 32'(1 << e) : {16'h0, w}, 4'h3, rsp);
      if (k == 2) exp_ev = exp_ev & ~w;
      else exp_ev[e] = 1'b0;
      chk({30'h0, rsp}, {30'h0, fsei_pkg::RESP_OKAY});
      poll();
    end
    s = diag_buf_sel_o;
    u_fsei_host.wr(fsei_pkg::A_CTRL, 32'h2, 4'h1, rsp);
    exp_ev[9] = 1'b1;
    chk({31'h0, diag_buf_sel_o}, {31'h0, ~s});
    poll();
    req_busy_i <= 1'b1;
    u_fsei_host.wr(fsei_pkg::A_CTRL, 32'h1, 4'h1, rsp);
    repeat (3) @(posedge mclk_i);
    chk({30'h0, go_offline_o, offline_o}, 32'h2);
    req_busy_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk({31'h0, offline_o}, 32'h1);
    exp_ev[1] = 1'b1;
    poll();
    u_fsei_host.wr(fsei_pkg::A_CTRL, 32'h8, 4'h1, rsp);
    u_fsei_host.wr(fsei_pkg::A_ACK, 32'hffff, 4'h3, rsp);
    exp_ev = 16'h0000;
    u_fsei_host.wr(fsei_pkg::A_MASK, 32'h0400, 4'h3, rsp);
    fire(11, 1'b1);
    chk({31'h0, irq_o}, 32'h1);
    u_fsei_host.rd(fsei_pkg::A_IND, rd_d, rsp);
    chk(rd_d & NT, 32'h0400);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h0);
    u_fsei_host.wr(fsei_pkg::A_CTRL, 32'h4, 4'h1, rsp);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h1);
    u_fsei_host.wr(fsei_pkg::A_ACK, 32'h0400, 4'h3, rsp);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h0);
    u_fsei_host.wr(fsei_pkg::A_TEST + 8'h10, 32'h1, 4'h1, rsp);
    repeat (TICKS + 4) @(posedge mclk_i);
    u_fsei_host.rd(fsei_pkg::A_TEST + 8'h10, rd_d, rsp);
    chk(rd_d, 32'h1);
    // address event pulses in the very cycle the acknowledge is applied
    fork
      u_fsei_host.wr(fsei_pkg::A_ACK, 32'h40, 4'h3, rsp);
      begin
        @(posedge mclk_i);
        address_change_stored_i <= 1'b1;
        @(posedge mclk_i);
        address_change_stored_i <= 1'b0;
      end
    join
    u_fsei_host.rd(fsei_pkg::A_TEST + 8'h18, rd_d, rsp);
    chk(rd_d, 32'h1);
    report_and_stop();
  end
endmodule : fsei_tb_top
`default_nettype wire
